//--- chained_clock_sync.sv
// chain clock synchronisation block: tick and seconds/nanoseconds counters behind AXI4-Lite
//
// Summary of operation
// - chain sync clears the tick counter of every board with its chain-reset flag set
// - sync accepted on master/isolated, slave flags error
// - master cable enable gates clock output, readable
// - slave status shows cable-driven or local ticking
// - flag stopped cable clock
// - follow flag: counter advanced by cable clock
// - chain-reset flag: counter cleared on chain sync
// - local enable flag gates counter advance
// - retain flag keeps value when disabled
// - cable clock stop halts following counters everywhere
// - stop/start/load/isolate/connect per counter separately
// - posix counters lockstep, values stay independent
// - four readable roles: master, pass, final, isolated
// - optional boot-triggered chain tick clear, default off
// - 64-bit tick counter, +1 per 400 ns
// - posix counter: seconds high, nanoseconds low
// - slave tick follows master increments and clears
`timescale 1ns/1ns
`include "clk_sync_defs.svh"
module chained_clock_sync
  import clk_sync_pkg::*;
#(
  parameter int TICK_CYC = `TICK_CYC,
  parameter int STOP_CYC = 2 * `TICK_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // chain link: clock and sync in from upstream and out downstream, boot in from downstream and out upstream
  input wire logic chain_clk_in,
  input wire logic chain_sync_in,
  input wire logic chain_boot_in,
  output logic chain_clk_out,
  output logic chain_sync_out,
  output logic chain_boot_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    role_t role;
    logic cable_en;
    logic auto_sync;
    cnt_flags_t tflags;
    cnt_flags_t pflags;
    logic [63:0] tick;
    logic [31:0] secs;
    logic [31:0] nanos;
    logic [31:0] load_hi;
    logic [31:0] load_lo;
    logic [15:0] div;
    logic [15:0] sync_cnt;
    logic [15:0] boot_cnt;
    logic [15:0] wd;
    logic clk_seen;
    logic sync_err;
    logic clk_out;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } st_t;

  st_t st_ff;
  st_t nxt_st;

  initial begin
    if (TICK_CYC < 2 || TICK_CYC > 65535) $error("TICK_CYC out of range");
    if (STOP_CYC <= TICK_CYC || STOP_CYC > 65535) $error("STOP_CYC out of range");
  end

  // ****************************************************************
  // link pins
  // ****************************************************************
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;

  pin_sync #(.WIDTH(3)) u_pins (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({chain_boot_in, chain_sync_in, chain_clk_in}),
    .level(pin_lvl),
    .rise(pin_rise)
  );

  // ****************************************************************
  // derived conditions
  // ****************************************************************
  logic is_master;
  logic is_slave;
  logic local_tick;
  logic cab_alive;
  logic chain_tick;
  logic wr_go;
  logic cmd_wr;
  logic cmd_sync;
  logic sync_do;
  logic boot_seen;
  logic tick_adv;
  logic posix_adv;
  logic absent_err;
  logic stopped_err;
  logic [31:0] status;
  logic [32:0] ns_sum;

  assign is_master = (st_ff.role == ROLE_MASTER);
  assign is_slave = (st_ff.role == ROLE_PASS) || (st_ff.role == ROLE_FINAL);
  // local 400 ns strobe from the divider
  assign local_tick = (st_ff.div == 16'(TICK_CYC - 1));
  // a slave counts the cable alive while edges keep coming
  assign cab_alive = st_ff.clk_seen && (st_ff.wd != 16'(STOP_CYC));
  // the one rate every following counter in the chain moves on
  always_comb begin
    unique case (st_ff.role)
      ROLE_MASTER: chain_tick = local_tick & st_ff.cable_en;
      ROLE_PASS, ROLE_FINAL: chain_tick = pin_rise[0];
      ROLE_ISOLATED: chain_tick = local_tick;
    endcase
  end
  // a following slave counter gets no local fallback, so it halts with the cable
  assign tick_adv = st_ff.tflags.local_en & (st_ff.tflags.follow ? chain_tick : local_tick);
  assign posix_adv = st_ff.pflags.local_en & (st_ff.pflags.follow ? chain_tick : local_tick);
  assign absent_err = is_slave & ~st_ff.clk_seen;
  assign stopped_err = is_master ? ~st_ff.cable_en : (is_slave & st_ff.clk_seen & ~cab_alive);
  assign wr_go = st_ff.aw_got & st_ff.w_got & ~st_ff.bvalid;
  assign cmd_wr = wr_go & (st_ff.awaddr == `ADDR_CMD) & st_ff.wstrb[0];
  assign cmd_sync = cmd_wr & st_ff.wdata[`CMD_SYNC];
  assign boot_seen = pin_rise[2] | (cmd_wr & st_ff.wdata[`CMD_BOOT]);
  // local request on master/isolated, upstream pulse on slaves, boot on master when enabled
  assign sync_do = (cmd_sync & ~is_slave) | (is_slave & pin_rise[1])
                 | (is_master & st_ff.auto_sync & boot_seen);
  assign ns_sum = {1'b0, st_ff.nanos} + {1'b0, `NS_PER_TICK};

  // status word, readable at both status offsets
  always_comb begin
    status = '0;
    status[1:0] = st_ff.role;
    status[2] = is_slave ? cab_alive : st_ff.cable_en;
    status[3] = is_slave & st_ff.tflags.follow & cab_alive;
    status[4] = is_slave & st_ff.pflags.follow & cab_alive;
    status[5] = absent_err;
    status[6] = stopped_err;
    status[7] = st_ff.sync_err;
    status[8] = st_ff.auto_sync;
  end

  // byte-lane merge for writable registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] stb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (stb[i]) res[i*8 +: 8] = dat[i*8 +: 8];
    end
    return res;
  endfunction

  // read decode; hi then lo of a counter is not atomic, software rereads on carry
  function automatic logic [32:0] rd_mux(input logic [11:0] a, input st_t s,
                                         input logic [31:0] stat);
    logic [32:0] r;
    r = '0;
    unique case (a)
      `ADDR_TICK_HI: r[31:0] = s.tick[63:32];
      `ADDR_TICK_LO: r[31:0] = s.tick[31:0];
      `ADDR_STAT_A, `ADDR_STAT_B: r[31:0] = stat;
      `ADDR_SECONDS: r[31:0] = s.secs;
      `ADDR_NANOS: r[31:0] = s.nanos;
      `ADDR_CTRL: r[31:0] = {28'h000_0000, s.auto_sync, s.cable_en, s.role};
      `ADDR_FLAGS: r[31:0] = {24'h00_0000, s.pflags, s.tflags};
      `ADDR_CMD: r[31:0] = '0;
      `ADDR_LOAD_HI: r[31:0] = s.load_hi;
      `ADDR_LOAD_LO: r[31:0] = s.load_lo;
      default: r[32] = 1'b1;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [32:0] rd;
    logic [31:0] ctrl;
    rd = '0;
    ctrl = '0;
    nxt_st = st_ff;
    nxt_st.div = local_tick ? '0 : st_ff.div + 16'h0001;

    // cable clock watchdog on slaves
    if (!is_slave || pin_rise[0]) begin
      nxt_st.wd = '0;
      nxt_st.clk_seen = is_slave;
    end else if (st_ff.wd != 16'(STOP_CYC)) begin
      nxt_st.wd = st_ff.wd + 16'h0001;
    end

    // clock out: master divider gated by cable enable, pass slave forwards
    unique case (st_ff.role)
      ROLE_MASTER: nxt_st.clk_out = st_ff.cable_en & (st_ff.div < 16'(TICK_CYC / 2));
      ROLE_PASS: nxt_st.clk_out = pin_lvl[0];
      ROLE_FINAL, ROLE_ISOLATED: nxt_st.clk_out = 1'b0;
    endcase

    // sync pulse held one tick period so slow samplers downstream see it
    if (sync_do && is_master) begin
      nxt_st.sync_cnt = 16'(TICK_CYC);
    end else if (st_ff.sync_cnt != '0) begin
      nxt_st.sync_cnt = st_ff.sync_cnt - 16'h0001;
    end
    // boot announce goes upstream, held likewise
    if (cmd_wr && st_ff.wdata[`CMD_BOOT]) begin
      nxt_st.boot_cnt = 16'(TICK_CYC);
    end else if (st_ff.boot_cnt != '0) begin
      nxt_st.boot_cnt = st_ff.boot_cnt - 16'h0001;
    end

    // tick counter: disable clear, advance, chain clear, load
    if (!st_ff.tflags.local_en && !st_ff.tflags.retain) begin
      nxt_st.tick = '0;
    end else if (tick_adv) begin
      nxt_st.tick = st_ff.tick + 64'h0000_0000_0000_0001;
    end
    if (sync_do && st_ff.tflags.chain_rst) nxt_st.tick = '0;
    if (cmd_wr && st_ff.wdata[`CMD_LOAD_TICK]) nxt_st.tick = {st_ff.load_hi, st_ff.load_lo};

    // seconds/nanoseconds counter
    if (!st_ff.pflags.local_en && !st_ff.pflags.retain) begin
      nxt_st.secs = '0;
      nxt_st.nanos = '0;
    end else if (posix_adv) begin
      if (ns_sum >= {1'b0, `NS_PER_SEC}) begin
        nxt_st.nanos = 32'(ns_sum - {1'b0, `NS_PER_SEC});
        nxt_st.secs = st_ff.secs + 32'h0000_0001;
      end else begin
        nxt_st.nanos = ns_sum[31:0];
      end
    end
    if (sync_do && st_ff.pflags.chain_rst) begin
      nxt_st.secs = '0;
      nxt_st.nanos = '0;
    end
    // loaded value stays this board's own, the chain never copies it
    if (cmd_wr && st_ff.wdata[`CMD_LOAD_POSIX]) begin
      nxt_st.secs = st_ff.load_hi;
      nxt_st.nanos = st_ff.load_lo;
    end

    // sync error: set wins over the clear in the same write
    if (cmd_wr && st_ff.wdata[`CMD_CLR_ERR]) nxt_st.sync_err = 1'b0;
    if (cmd_sync && is_slave) nxt_st.sync_err = 1'b1;

    // axi write channels taken in either order, then one register write
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = {s_axi_awaddr[11:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (wr_go) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      rd = rd_mux(st_ff.awaddr, st_ff, status);
      nxt_st.bresp = rd[32] ? `RESP_SLVERR : `RESP_OKAY;
      unique case (st_ff.awaddr)
        `ADDR_CTRL: begin
          ctrl = merge({28'h000_0000, st_ff.auto_sync, st_ff.cable_en, st_ff.role},
                       st_ff.wdata, st_ff.wstrb);
          nxt_st.role = role_t'(ctrl[1:0]);
          nxt_st.cable_en = ctrl[2];
          nxt_st.auto_sync = ctrl[3];
          if (ctrl[1:0] != st_ff.role) begin
            nxt_st.clk_seen = 1'b0;
            nxt_st.wd = '0;
          end
        end
        `ADDR_FLAGS: begin
          // stop/start and isolate/connect per counter
          ctrl = merge({24'h00_0000, st_ff.pflags, st_ff.tflags}, st_ff.wdata, st_ff.wstrb);
          nxt_st.tflags = cnt_flags_t'(ctrl[3:0]);
          nxt_st.pflags = cnt_flags_t'(ctrl[7:4]);
        end
        `ADDR_LOAD_HI: nxt_st.load_hi = merge(st_ff.load_hi, st_ff.wdata, st_ff.wstrb);
        `ADDR_LOAD_LO: nxt_st.load_lo = merge(st_ff.load_lo, st_ff.wdata, st_ff.wstrb);
        default: ctrl = '0;
      endcase
    end
    if (st_ff.bvalid && s_axi_bready) nxt_st.bvalid = 1'b0;

    // axi read, answered the cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      rd = rd_mux({s_axi_araddr[11:2], 2'b00}, st_ff, status);
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd[31:0];
      nxt_st.rresp = rd[32] ? `RESP_SLVERR : `RESP_OKAY;
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.role <= ROLE_ISOLATED;
      st_ff.cable_en <= `RST_CABLE_EN;
      st_ff.auto_sync <= `RST_AUTO_SYNC;
      st_ff.tflags <= cnt_flags_t'(`RST_FLAGS);
      st_ff.pflags <= cnt_flags_t'(`RST_FLAGS);
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs
  assign s_axi_awready = ~st_ff.aw_got & ~st_ff.bvalid;
  assign s_axi_wready = ~st_ff.w_got & ~st_ff.bvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = ~st_ff.rvalid;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign chain_clk_out = st_ff.clk_out;
  // pass slaves forward the sync downstream and the boot upstream
  assign chain_sync_out = (st_ff.sync_cnt != '0) | ((st_ff.role == ROLE_PASS) & pin_lvl[1]);
  assign chain_boot_out = (st_ff.boot_cnt != '0) | (is_slave & pin_lvl[2]);

  // ****************************************************************
  // checks
  // ****************************************************************
  a_sync_reject: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_sync && is_slave |-> (!sync_do || pin_rise[1]) ##1 st_ff.sync_err)
    else $error("sync on slave not flagged");
  a_sync_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_do && st_ff.tflags.chain_rst && !(cmd_wr && st_ff.wdata[`CMD_LOAD_TICK])
    |=> st_ff.tick == '0)
    else $error("tick not cleared by chain sync");
  a_cable_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_master && !st_ff.cable_en) [*2] |-> !chain_clk_out)
    else $error("cable clock driven while disabled");
  a_stopped_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    is_slave && st_ff.clk_seen && !pin_rise[0] && !wr_go && st_ff.wd == 16'(STOP_CYC - 1)
    |=> status[6])
    else $error("stopped clock not flagged");
  a_retain_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !st_ff.tflags.local_en && st_ff.tflags.retain && !sync_do && !cmd_wr
    |=> st_ff.tick == $past(st_ff.tick))
    else $error("retained tick changed while disabled");
  a_disable_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    !st_ff.tflags.local_en && !st_ff.tflags.retain && !cmd_wr |=> st_ff.tick == '0)
    else $error("disabled tick not cleared");
  a_nanos_range: assert property (@(posedge aclk) disable iff (!aresetn)
    posix_adv && st_ff.nanos < `NS_PER_SEC && !sync_do && !cmd_wr
    |=> st_ff.nanos < `NS_PER_SEC && (st_ff.nanos == $past(st_ff.nanos) + `NS_PER_TICK
        || st_ff.secs == $past(st_ff.secs) + 32'h0000_0001))
    else $error("nanoseconds step or wrap wrong");
  a_follow_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    is_master && !st_ff.cable_en && st_ff.pflags.follow && st_ff.pflags.local_en
    && !sync_do && !cmd_wr |=> $stable(st_ff.nanos) && $stable(st_ff.secs))
    else $error("following counter moved with cable stopped");
  a_tick_step: assert property (@(posedge aclk) disable iff (!aresetn)
    tick_adv && !sync_do && !cmd_wr |=> st_ff.tick == $past(st_ff.tick) + 64'h0000_0000_0000_0001)
    else $error("tick did not step by one");

endmodule

//--- clk_sync_defs.svh
// register map, field positions, reset values and timing counts of the chain clock block
`ifndef CLK_SYNC_DEFS_SVH
`define CLK_SYNC_DEFS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 4
`define TICK_PERIOD_NS 400
`define TICK_CYC (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define NS_PER_TICK 32'h0000_0190
`define NS_PER_SEC 32'h3B9A_CA00

// ****************************************************************
// register byte addresses
// ****************************************************************
`define ADDR_TICK_HI 12'h000
`define ADDR_TICK_LO 12'h008
`define ADDR_STAT_A 12'h010
`define ADDR_SECONDS 12'h100
`define ADDR_NANOS 12'h108
`define ADDR_STAT_B 12'h110
`define ADDR_CTRL 12'h200
`define ADDR_FLAGS 12'h204
`define ADDR_CMD 12'h208
`define ADDR_LOAD_HI 12'h20C
`define ADDR_LOAD_LO 12'h210

// ****************************************************************
// command bits (write only, self clearing)
// ****************************************************************
`define CMD_SYNC 0
`define CMD_LOAD_TICK 1
`define CMD_LOAD_POSIX 2
`define CMD_BOOT 3
`define CMD_CLR_ERR 4

// ****************************************************************
// reset values
// ****************************************************************
`define RST_CABLE_EN 1'b1
`define RST_AUTO_SYNC 1'b0
`define RST_FLAGS 4'h7

// ****************************************************************
// bus answers
// ****************************************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- clk_sync_pkg.sv
// types shared by the chain clock block
package clk_sync_pkg;

  // chain role of this board
  typedef enum logic [1:0] {
    ROLE_MASTER,
    ROLE_PASS,
    ROLE_FINAL,
    ROLE_ISOLATED
  } role_t;

  // per-counter control flags
  typedef struct packed {
    logic retain;
    logic local_en;
    logic chain_rst;
    logic follow;
  } cnt_flags_t;

endpackage

//--- pin_sync.sv
// two-stage synchroniser with rising edge detect for link pins
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // raw pins
  input wire logic [WIDTH-1:0] pin_in,
  // synchronised level and one-cycle rise pulse
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] last;
  } sync_st_t;

  sync_st_t st_ff;
  sync_st_t nxt_st;

  initial begin
    if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second one
  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta = pin_in;
    nxt_st.stable = st_ff.meta;
    nxt_st.last = st_ff.stable;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.stable;
  assign rise = st_ff.stable & ~st_ff.last;

endmodule

//--- chain_peer.sv
// model of the neighbouring boards that drive the chain link pins
`timescale 1ns/1ns
module chain_peer (
  // link pins toward the block
  output logic chain_clk,
  output logic chain_sync,
  output logic chain_boot
);
  // ****************************************************************
  // link idles low between frames
  // ****************************************************************
  initial begin
    chain_clk = 1'b0;
    chain_sync = 1'b0;
    chain_boot = 1'b0;
  end
  // n periods of the 48 ns cable clock; offset keeps it unrelated to aclk
  task automatic send_edges(input int n);
    #7;
    repeat (n) begin
      chain_clk = 1'b1;
      #24;
      chain_clk = 1'b0;
      #24;
    end
  endtask
  // chain-wide sync from the master board, wide enough for a 2-ff synchroniser
  task automatic pulse_sync();
    #7;
    chain_sync = 1'b1;
    #96;
    chain_sync = 1'b0;
  endtask
  // start-up announce from another board
  task automatic pulse_boot();
    #7;
    chain_boot = 1'b1;
    #96;
    chain_boot = 1'b0;
  endtask
endmodule

//--- test_chained_clock_sync.sv
// self-checking bench for the chain clock block
`timescale 1ns/1ns
`include "clk_sync_defs.svh"
module test_chained_clock_sync;
  localparam int TC = 8;
  localparam int SC = 40;
  logic aclk, aresetn, awv, awr, wv, wrd, bv, brd, arv, arr, rv, rrd;
  logic ci, si, bi, co, so, bo;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdt, rd, seed;
  logic [1:0] bre, rre, rs;
  logic [63:0] te;
  int n_errors, comparisons, h;

  chained_clock_sync #(.TICK_CYC(TC), .STOP_CYC(SC)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bre),
    .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rre), .s_axi_rvalid(rv),
    .s_axi_rready(rrd), .chain_clk_in(ci), .chain_sync_in(si), .chain_boot_in(bi),
    .chain_clk_out(co), .chain_sync_out(so), .chain_boot_out(bo));
  chain_peer u_peer (.chain_clk(ci), .chain_sync(si), .chain_boot(bi));

  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // ready is sampled mid-cycle, release follows at the next rising edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int t;
    logic ah, wh, bh;
    t = 0;
    bh = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    while (!bh && t < 200) begin
      @(negedge aclk);
      ah = awv && awr;
      wh = wv && wrd;
      bh = bv && brd;
      rs = bre;
      t++;
      @(posedge aclk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
      if (bh) brd <= 1'b0;
    end
    if (!bh) n_errors++;
  endtask
  task automatic rdx(input logic [11:0] a);
    int t;
    logic ah, rh;
    t = 0;
    rh = 1'b0;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    while (!rh && t < 200) begin
      @(negedge aclk);
      ah = arv && arr;
      rh = rv && rrd;
      rd = rdt;
      rs = rre;
      t++;
      @(posedge aclk);
      if (ah) arv <= 1'b0;
      if (rh) rrd <= 1'b0;
    end
    if (!rh) n_errors++;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    rdx(a);
    chk(rd & m, e);
  endtask
  // counts cycles with the cable clock output high
  task automatic hcnt(input int n);
    h = 0;
    repeat (n) begin
      @(negedge aclk);
      if (co === 1'b1) h++;
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    {awv, wv, brd, arv, rrd, awa, ara, wd} = '0;
    aresetn = 1'b0;
    seed = 32'h0000_3D87;
    n_errors = 0;
    comparisons = 0;
    cyc(6);
    aresetn <= 1'b1;
    rdc(`ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0007);
    rdc(`ADDR_FLAGS, 32'hFFFF_FFFF, 32'h0000_0077);
    rdc(12'h300, 32'hFFFF_FFFF, 32'h0000_0000);
    chk(32'(rs), 32'(`RESP_SLVERR));
    wr(12'h300, 32'h0000_0001);
    chk(32'(rs), 32'(`RESP_SLVERR));
    // isolated board accepts sync and restarts from zero; let it run up first
    cyc(10 * TC);
    wr(`ADDR_CMD, 32'h0000_0001);
    rdc(`ADDR_STAT_A, 32'h0000_0083, 32'h0000_0003);
    rdx(`ADDR_TICK_LO);
    chk(32'(rd < 32'd4), 32'd1);
    // stopped with retain holds, without retain clears
    wr(`ADDR_FLAGS, 32'h0000_007B);
    rdx(`ADDR_TICK_LO);
    te = 64'(rd);
    cyc(5 * TC);
    rdc(`ADDR_TICK_LO, 32'hFFFF_FFFF, te[31:0]);
    wr(`ADDR_FLAGS, 32'h0000_0073);
    rdc(`ADDR_TICK_LO, 32'hFFFF_FFFF, 32'h0000_0000);
    // pass-through slave follows the cable only
    wr(`ADDR_CTRL, 32'h0000_0005);
    wr(`ADDR_FLAGS, 32'h0000_0077);
    rdc(`ADDR_STAT_A, 32'h0000_0023, 32'h0000_0021);
    wr(`ADDR_CMD, 32'h0000_0001);
    rdc(`ADDR_STAT_A, 32'h0000_0080, 32'h0000_0080);
    wr(`ADDR_CMD, 32'h0000_0010);
    rdc(`ADDR_STAT_A, 32'h0000_0080, 32'h0000_0000);
    seed = xs(seed);
    te[63:32] = seed;
    seed = xs(seed);
    te[31:0] = seed;
    wr(`ADDR_LOAD_HI, te[63:32]);
    wr(`ADDR_LOAD_LO, te[31:0]);
    wr(`ADDR_CMD, 32'h0000_0002);
    u_peer.send_edges(5);
    cyc(8);
    te = te + 64'd5;
    rdc(`ADDR_TICK_HI, 32'hFFFF_FFFF, te[63:32]);
    rdc(`ADDR_TICK_LO, 32'hFFFF_FFFF, te[31:0]);
    rdc(`ADDR_STAT_A, 32'h0000_0038, 32'h0000_0018);
    // tick frozen while the seconds counter is loaded and runs across a wrap
    wr(`ADDR_FLAGS, 32'h0000_007B);
    wr(`ADDR_LOAD_HI, 32'h0000_0005);
    wr(`ADDR_LOAD_LO, `NS_PER_SEC - 32'h0000_0320);
    wr(`ADDR_CMD, 32'h0000_0004);
    u_peer.send_edges(3);
    cyc(8);
    rdc(`ADDR_SECONDS, 32'hFFFF_FFFF, 32'h0000_0006);
    rdc(`ADDR_NANOS, 32'hFFFF_FFFF, 32'h0000_0190);
    rdc(`ADDR_TICK_LO, 32'hFFFF_FFFF, te[31:0]);
    wr(`ADDR_FLAGS, 32'h0000_0077);
    u_peer.pulse_sync();
    cyc(8);
    rdc(`ADDR_TICK_HI, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(`ADDR_TICK_LO, 32'hFFFF_FFFF, 32'h0000_0000);
    // final slave: counts cable edges but forwards no clock
    wr(`ADDR_CTRL, 32'h0000_0006);
    fork
      u_peer.send_edges(2);
      hcnt(30);
    join
    chk(h, 0);
    rdc(`ADDR_TICK_LO, 32'hFFFF_FFFF, 32'h0000_0002);
    cyc(SC + 20);
    rdc(`ADDR_STAT_B, 32'h0000_0040, 32'h0000_0040);
    // master: cable clock gated by its enable
    wr(`ADDR_CTRL, 32'h0000_0000);
    hcnt(3 * TC);
    chk(h, 0);
    rdc(`ADDR_STAT_A, 32'h0000_0047, 32'h0000_0040);
    wr(`ADDR_CTRL, 32'h0000_0004);
    hcnt(3 * TC);
    chk(h, 3 * TC / 2);
    wr(`ADDR_CMD, 32'h0000_0001);
    @(negedge aclk);
    chk(32'(so), 32'd1);
    wr(`ADDR_CMD, 32'h0000_0008);
    @(negedge aclk);
    chk(32'(bo), 32'd1);
    wr(`ADDR_CTRL, 32'h0000_000C);
    rdc(`ADDR_STAT_A, 32'h0000_0100, 32'h0000_0100);
    cyc(200);
    rdx(`ADDR_TICK_LO);
    chk(32'(rd >= 32'd20), 32'd1);
    u_peer.pulse_boot();
    cyc(8);
    rdx(`ADDR_TICK_LO);
    chk(32'(rd < 32'd8), 32'd1);
    // mid-run reset brings the control word back to its defaults
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    rdc(`ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0007);
    summarize();
  end

  // hang guard
  initial begin
    cyc(20000);
    n_errors++;
    summarize();
  end
endmodule
